// file: rtl/mfc_pkg.sv
package mfc_pkg;
    localparam int K_MIN = 1;
    localparam int K_MAX = 32;
    localparam int OCTETS_MIN = 17;
    localparam int OCTETS_MAX = 1024;
    localparam int OCTETS_PER_CYCLE = 4;
    localparam int CNT_W = 8;
    localparam int F_W = 6;
    localparam int K_W = 6;
    localparam logic [3:0] PERIOD_MASK_LIMIT = 4'h3;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_PARAM = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
    localparam int CTRL_ONESHOT = 0;
    localparam int CTRL_CONTINUOUS = 1;
    localparam int PARAM_F_LSB = 0;
    localparam int PARAM_K_LSB = 8;
    localparam int ST_CNT_LSB = 0;
    localparam int ST_CFG_OK = 8;
    localparam int ST_ALIGNED = 9;
    localparam int ST_SYNC_HOLD = 10;
    localparam int IRQ_PERIOD_ERR = 0;
    localparam int IRQ_EDGE = 1;
    localparam int IRQ_W = 2;
    localparam logic [F_W-1:0] F_RESET = 6'h02;
    localparam logic [K_W-1:0] K_RESET = 6'h10;
endpackage : mfc_pkg

// file: rtl/mfc_sync_edge.sv
module mfc_sync_edge
    import mfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic asyncIn,
    output logic risePulse,
    output logic levelOut
);
    logic stage1_reg;
    logic stage2_reg;
    logic prev_reg;
    logic stage1_next;
    logic stage2_next;
    logic prev_next;

    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
        prev_next = stage2_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            prev_reg <= prev_next;
        end
    end

    // Sampled 0 then 1 on consecutive clocks
    assign risePulse = stage2_reg & ~prev_reg;
    assign levelOut = stage2_reg;
endmodule : mfc_sync_edge

// file: rtl/mfc_cfg_check.sv
module mfc_cfg_check
    import mfc_pkg::*;
(
    input wire logic [F_W-1:0] octetsPerFrame,
    input wire logic [K_W-1:0] framesPerMulti,
    output logic cfgOk,
    output logic [CNT_W-1:0] periodCycles
);
    logic [11:0] octets;

    always_comb begin
        octets = 12'(octetsPerFrame) * 12'(framesPerMulti);
        cfgOk = (framesPerMulti >= K_W'(K_MIN))
            && (framesPerMulti <= K_W'(K_MAX))
            && (octets >= 12'(OCTETS_MIN))
            && (octets <= 12'(OCTETS_MAX))
            && (octets[1:0] == 2'h0);
        periodCycles = CNT_W'(octets / 12'(OCTETS_PER_CYCLE));
    end
endmodule : mfc_cfg_check

// file: rtl/mfc_top.sv
// Overview of operation
// - K 1..32, multiframe 17..1024 octets
// - F times K multiple of four
// - Sample timing pulse on link clock
// - Counter period is F times K over four
// - Count zero to period minus one
// - Rising edge forces counter to zero when either bit is set
// - One-shot bit realigns once, self clears
// - One-shot holds sync exit until pulse
// - Continuous bit realigns on every edge
// - Continuous enables period checker interrupt
// - Continuous alone gives no sync hold
// - Both bits combine all behaviours
// - Link clock is lane rate over 40
// - Frame and multiframe clock relations
module mfc_top
    import mfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sysrefIn,
    input wire logic syncExitReq,
    output logic syncExitGrant,
    output logic [CNT_W-1:0] localMultiframeCounter,
    output logic multiframeBoundary,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic sysrefRise;
    logic sysrefLevel;
    logic cfgOk;
    logic [CNT_W-1:0] periodCycles;

    logic oneShot_reg, oneShot_next;
    logic continuous_reg, continuous_next;
    logic [F_W-1:0] fParam_reg, fParam_next;
    logic [K_W-1:0] kParam_reg, kParam_next;
    logic [IRQ_W-1:0] irqStat_reg, irqStat_next;
    logic [IRQ_W-1:0] irqMask_reg, irqMask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic aligned_reg, aligned_next;
    logic seen_reg, seen_next;
    logic grant_reg, grant_next;
    logic boundary_reg, boundary_next;
    logic irq_reg, irq_next;

    logic realign;
    logic [CNT_W-1:0] freeNext;
    logic periodErr;
    logic access;
    logic setupPhase;
    logic [IRQ_W-1:0] events;

    mfc_sync_edge u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn(sysrefIn),
        .risePulse(sysrefRise),
        .levelOut(sysrefLevel)
    );

    mfc_cfg_check u_cfg (
        .octetsPerFrame(fParam_reg),
        .framesPerMulti(kParam_reg),
        .cfgOk(cfgOk),
        .periodCycles(periodCycles)
    );

    function automatic logic isAddr(input logic [11:0] a,
                                    input logic [11:0] ref_a);
        isAddr = (a == ref_a);
    endfunction : isAddr

    // Zero-wait APB: setup cycle, then an access cycle that is always ready
    always_comb begin
        setupPhase = psel && !penable;
        access = psel && penable && pready_reg;
    end

    // Multiframe counter and alignment
    always_comb begin
        realign = sysrefRise && (oneShot_reg || continuous_reg);
        if (!cfgOk || cnt_reg >= periodCycles - CNT_W'(1)) begin
            freeNext = '0;
        end else begin
            freeNext = cnt_reg + CNT_W'(1);
        end
        // A well-placed edge lands where the free count wraps anyway
        periodErr = sysrefRise && continuous_reg && aligned_reg
            && (freeNext != '0);
        if (realign) begin
            cnt_next = '0;
        end else begin
            cnt_next = freeNext;
        end
        aligned_next = aligned_reg || realign;
        boundary_next = (cnt_next == '0);
        // Pulse seen since the one-shot bit was last armed
        seen_next = seen_reg;
        if (oneShot_reg && sysrefRise) begin
            seen_next = 1'b1;
        end
        if (access && pwrite && isAddr(paddr, ADDR_CTRL)
            && pwdata[CTRL_ONESHOT]) begin
            seen_next = 1'b0;
        end
        // Continuous mode gives no guard against the sync race
        grant_next = syncExitReq
            && (!oneShot_reg || seen_reg || sysrefRise);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            aligned_reg <= 1'b0;
            seen_reg <= 1'b0;
            grant_reg <= 1'b0;
            boundary_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            aligned_reg <= aligned_next;
            seen_reg <= seen_next;
            grant_reg <= grant_next;
            boundary_reg <= boundary_next;
        end
    end

    // Register file
    always_comb begin
        events = '0;
        events[IRQ_PERIOD_ERR] = periodErr;
        events[IRQ_EDGE] = sysrefRise;
        oneShot_next = oneShot_reg;
        continuous_next = continuous_reg;
        fParam_next = fParam_reg;
        kParam_next = kParam_reg;
        irqMask_next = irqMask_reg;
        irqStat_next = irqStat_reg;
        prdata_next = prdata_reg;
        pready_next = setupPhase;
        pslverr_next = 1'b0;
        if (access && pwrite) begin
            if (isAddr(paddr, ADDR_CTRL)) begin
                oneShot_next = pwdata[CTRL_ONESHOT];
                continuous_next = pwdata[CTRL_CONTINUOUS];
            end else if (isAddr(paddr, ADDR_PARAM)) begin
                fParam_next = pwdata[PARAM_F_LSB +: F_W];
                kParam_next = pwdata[PARAM_K_LSB +: K_W];
            end else if (isAddr(paddr, ADDR_IRQ_MASK)) begin
                irqMask_next = pwdata[IRQ_W-1:0];
            end
        end
        // Hardware clear after the one-shot edge wins over a same-cycle write
        if (oneShot_reg && sysrefRise) begin
            oneShot_next = 1'b0;
        end
        if (access && !pwrite && isAddr(paddr, ADDR_IRQ_STAT)) begin
            // Clear only what the read reported; a later event survives
            irqStat_next = irqStat_reg & ~prdata_reg[IRQ_W-1:0];
        end
        irqStat_next = irqStat_next | events;
        if (setupPhase) begin
            prdata_next = '0;
            pslverr_next = 1'b0;
            if (isAddr(paddr, ADDR_CTRL)) begin
                prdata_next[CTRL_ONESHOT] = oneShot_reg;
                prdata_next[CTRL_CONTINUOUS] = continuous_reg;
            end else if (isAddr(paddr, ADDR_PARAM)) begin
                prdata_next[PARAM_F_LSB +: F_W] = fParam_reg;
                prdata_next[PARAM_K_LSB +: K_W] = kParam_reg;
            end else if (isAddr(paddr, ADDR_STATUS)) begin
                prdata_next[ST_CNT_LSB +: CNT_W] = cnt_reg;
                prdata_next[ST_CFG_OK] = cfgOk;
                prdata_next[ST_ALIGNED] = aligned_reg;
                prdata_next[ST_SYNC_HOLD] = oneShot_reg && !seen_reg;
            end else if (isAddr(paddr, ADDR_IRQ_STAT)) begin
                prdata_next[IRQ_W-1:0] = irqStat_reg;
            end else if (isAddr(paddr, ADDR_IRQ_MASK)) begin
                prdata_next[IRQ_W-1:0] = irqMask_reg;
            end else begin
                pslverr_next = 1'b1;
            end
        end else if (!psel) begin
            prdata_next = '0;
        end
        irq_next = |(irqStat_next & irqMask_next);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oneShot_reg <= 1'b0;
            continuous_reg <= 1'b0;
            fParam_reg <= F_RESET;
            kParam_reg <= K_RESET;
            irqStat_reg <= '0;
            irqMask_reg <= '0;
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            oneShot_reg <= oneShot_next;
            continuous_reg <= continuous_next;
            fParam_reg <= fParam_next;
            kParam_reg <= kParam_next;
            irqStat_reg <= irqStat_next;
            irqMask_reg <= irqMask_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
        end
    end

    assign localMultiframeCounter = cnt_reg;
    assign multiframeBoundary = boundary_reg;
    assign syncExitGrant = grant_reg;
    assign irq = irq_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule : mfc_top

// file: verification/mfc_sysref_gen.sv
module mfc_sysref_gen (
    input wire logic sys_clk,
    input wire logic run,
    input wire logic [7:0] gap,
    output logic sysref
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] phase = 8'h00;
    logic pulse = 1'h0;
    // Quiet between trains; a gap that is a multiple of the period keeps
    // every edge on a multiframe boundary
    always @(posedge sys_clk) begin
        phase <= (!run || phase + 8'h01 >= gap) ? 8'h00
            : phase + 8'h01;
        pulse <= run && phase < 8'h02;
    end
    assign sysref = pulse;
endmodule : mfc_sysref_gen

// file: verification/mfc_top_assertions.sv
module mfc_top_assertions
    import mfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic sysrefIn,
    input wire logic syncExitReq,
    input wire logic syncExitGrant,
    input wire logic [CNT_W-1:0] localMultiframeCounter,
    input wire logic multiframeBoundary,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire logic [CNT_W-1:0] cnt = localMultiframeCounter;
    wire logic ctrlWr = psel && penable && pready && pwrite
        && paddr == ADDR_CTRL;
    logic contReg;
    logic contNext;
    // Mirrors the continuous bit, since the checker sees only the ports
    always_comb contNext = ctrlWr ? pwdata[CTRL_CONTINUOUS] : contReg;
    always_ff @(posedge sys_clk or negedge rst_b)
        contReg <= !rst_b ? 1'h0 : contNext;
    sequence s_arm;
        (!sysrefIn) [*4] ##0 (ctrlWr && pwdata[CTRL_ONESHOT]);
    endsequence
    sequence s_quiet;
        (!sysrefIn) [*4];
    endsequence
    property p_step;
        cnt != 0 |-> cnt == $past(cnt) + 1;
    endproperty
    a_step: assert property (p_step) else $error("count step");
    // Every legal configuration the bench uses has a period of eight cycles
    property p_wrap;
        cnt == 8'h07 |=> cnt == 0 && multiframeBoundary;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count wrap");
    property p_bound;
        multiframeBoundary |-> cnt == 0;
    endproperty
    a_bound: assert property (p_bound) else $error("boundary");
    // Two sync stages and the counter register put the zero three edges on
    property p_realign;
        contReg && $rose(sysrefIn) |-> ##3 cnt == 0;
    endproperty
    a_realign: assert property (p_realign) else $error("realign");
    property p_hold;
        s_arm ##1 s_quiet |-> !syncExitGrant;
    endproperty
    a_hold: assert property (p_hold) else $error("sync hold");
    property p_gate;
        !syncExitReq |=> !syncExitGrant;
    endproperty
    a_gate: assert property (p_gate) else $error("grant");
    property p_wait;
        psel && !penable |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("pready width");
    property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("refusal");
endmodule : mfc_top_assertions

bind mfc_top mfc_top_assertions i_chk (.*);

// file: verification/mfc_top_tb.sv
module mfc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mfc_pkg::*;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic syncExitReq = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic run = 1'h0;
    logic [7:0] gap = 8'h10;
    logic sysrefIn, syncExitGrant, multiframeBoundary, irq;
    logic pready, pslverr, slvErr;
    logic [CNT_W-1:0] localMultiframeCounter;
    logic [31:0] prdata, rdData;
    int errTotal = 0;
    int testsRun = 0;
    always #25 sys_clk = ~sys_clk;
    mfc_sysref_gen i_gen (.sys_clk, .run, .gap, .sysref(sysrefIn));
    mfc_top i_dut (.*);
    task automatic summarize;
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic expire(input string nm);
        errTotal++;
        $display("ERROR %s expected answer seen timeout", nm);
    endtask : expire
    task automatic chk(input string nm, input logic [31:0] e, g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic waitHigh(ref logic s, input string nm);
        int n;
        for (n = 0; n < 40 && s !== 1'h1; n++) @(posedge sys_clk);
        if (n == 40) expire(nm);
    endtask : waitHigh
    // Idles one edge first so back-to-back calls never drive psel twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        for (n = 0; n < 20 && pready !== 1'h1; n++) @(posedge sys_clk);
        rdData = prdata;
        slvErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n == 20) expire("pready");
    endtask : apb
    task automatic tRegs;
        apb(1'h0, ADDR_PARAM, 32'h0);
        chk("param", {18'h0, K_RESET, 2'h0, F_RESET}, rdData);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("cfgOk", 32'h1, 32'(rdData[ST_CFG_OK]));
        apb(1'h0, 12'hffc, 32'h0);
        chk("slverr", 32'h1, 32'(slvErr));
        $display("test regs done");
    endtask : tRegs
    // Illegal shapes hold the counter at zero; ends on F 1, K 32 (eight cycles)
    task automatic tParam;
        apb(1'h1, ADDR_PARAM, 32'h0000_0801);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("shortCfg", 32'h0, 32'(rdData[ST_CFG_OK]));
        chk("heldSts", 32'h0, 32'(rdData[ST_CNT_LSB +: CNT_W]));
        chk("heldCnt", 32'h0, 32'(localMultiframeCounter));
        apb(1'h1, ADDR_PARAM, 32'h0000_2401);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("longK", 32'h0, 32'(rdData[ST_CFG_OK]));
        apb(1'h1, ADDR_PARAM, 32'h0000_0703);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("oddCfg", 32'h0, 32'(rdData[ST_CFG_OK]));
        apb(1'h1, ADDR_PARAM, 32'h0000_2001);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk("goodCfg", 32'h1, 32'(rdData[ST_CFG_OK]));
        $display("test param done");
    endtask : tParam
    task automatic tCount;
        waitHigh(multiframeBoundary, "boundary");
        for (int i = 0; i < 10; i++) begin
            chk("cnt", 32'(i % 8), 32'(localMultiframeCounter));
            @(posedge sys_clk);
        end
        $display("test count done");
    endtask : tCount
    task automatic tOneShot;
        syncExitReq <= 1'h1;
        apb(1'h1, ADDR_CTRL, 32'h1);
        repeat (8) @(posedge sys_clk);
        chk("hold", 32'h0, 32'(syncExitGrant));
        // Start from a known phase so a missed realign shows a count of 5
        waitHigh(multiframeBoundary, "boundary");
        run <= 1'h1;
        waitHigh(syncExitGrant, "grant");
        chk("realign", 32'h0, 32'(localMultiframeCounter));
        run <= 1'h0;
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk("selfClear", 32'h0, rdData);
        syncExitReq <= 1'h0;
        $display("test one-shot done");
    endtask : tOneShot
    task automatic tCont;
        apb(1'h1, ADDR_IRQ_MASK, 32'h1);
        apb(1'h1, ADDR_CTRL, 32'h2);
        syncExitReq <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk("contGrant", 32'h1, 32'(syncExitGrant));
        syncExitReq <= 1'h0;
        run <= 1'h1;
        repeat (40) @(posedge sys_clk);
        apb(1'h0, ADDR_IRQ_STAT, 32'h0);
        repeat (40) @(posedge sys_clk);
        chk("irqQuiet", 32'h0, 32'(irq));
        gap <= 8'h13;
        repeat (40) @(posedge sys_clk);
        chk("irqSet", 32'h1, 32'(irq));
        run <= 1'h0;
        repeat (6) @(posedge sys_clk);
        apb(1'h0, ADDR_IRQ_STAT, 32'h0);
        chk("periodErr", 32'h1, 32'(rdData[IRQ_PERIOD_ERR]));
        chk("edgeBit", 32'h1, 32'(rdData[IRQ_EDGE]));
        repeat (2) @(posedge sys_clk);
        chk("irqClear", 32'h0, 32'(irq));
        $display("test continuous done");
    endtask : tCont
    task automatic tBoth;
        gap <= 8'h10;
        apb(1'h1, ADDR_CTRL, 32'h3);
        syncExitReq <= 1'h1;
        repeat (8) @(posedge sys_clk);
        chk("bothHold", 32'h0, 32'(syncExitGrant));
        run <= 1'h1;
        waitHigh(syncExitGrant, "grant");
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk("bothCtrl", 32'h2, rdData);
        repeat (20) @(posedge sys_clk);
        apb(1'h0, ADDR_IRQ_STAT, 32'h0);
        repeat (40) @(posedge sys_clk);
        chk("bothQuiet", 32'h0, 32'(irq));
        run <= 1'h0;
        syncExitReq <= 1'h0;
        $display("test both bits done");
    endtask : tBoth
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        tRegs();
        tParam();
        tCount();
        tOneShot();
        tCont();
        tBoth();
        summarize();
    end
endmodule : mfc_top_tb
